// File: logic/ee_dev_end.sv
// Slave end of the two-wire serial EEPROM: addressing, page buffer, write cycle.
// The serial clock is a clock port; pins are synchronised into clk_sys.
`timescale 1ns/1ps
module ee_dev_end
  import ee_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              ce,
  ee_link_if.dev                 link,
  input  wire logic              wp,
  input  wire logic              chip_addr_pin_0,
  input  wire logic              chip_addr_pin_1,
  input  wire logic              chip_addr_pin_2,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [BYTE_W-1:0] rd_data_ff,
  output logic                   busy_ff
);
  typedef enum logic [3:0] {
    S_IDLE, S_CTRL, S_ADDR_HI, S_ADDR_LO, S_DATA, S_READ, S_SKIP, S_COMMIT, S_WAIT
  } ee_dev_state_e;

  localparam int TMR_W = $clog2(WRITE_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Serial clock domain
  // ----------------------------------------------------------------------
  // Only the data bit lives here. It is stable for a whole clock period, so the
  // system side may read it once the synchronised clock level shows a rise.
  logic bit_ff;

  always_ff @(posedge link.scl) begin
    bit_ff <= link.sda;
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------------------------------------
  logic [5:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       wp_s;
  logic [2:0] sel_s;
  logic       scl_d_ff;
  logic       sda_d_ff;

  ee_sync #(.W(6)) u_sync (
    .clk    (clk_sys),
    .resetn (resetn),
    .ce     (ce),
    .d      ({link.scl, link.sda, wp, chip_addr_pin_2, chip_addr_pin_1, chip_addr_pin_0}),
    .q      (pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign wp_s  = pins_s[3];
  assign sel_s = pins_s[2:0];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_d_ff <= 1'b0;
      sda_d_ff <= 1'b0;
    end else if (ce) begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;

  assign start_ev = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_ev  = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  assign rise_ev  = scl_s && !scl_d_ff;
  assign fall_ev  = !scl_s && scl_d_ff;

  // ----------------------------------------------------------------------
  // Byte assembly
  // ----------------------------------------------------------------------
  ee_dev_state_e     state_ff;
  ee_dev_state_e     nxt_state;
  logic [3:0]        cnt_ff;
  logic [BYTE_W-1:0] sh_ff;
  logic [BYTE_W-1:0] in_byte;
  logic              byte_done;
  logic              busy;
  logic              ack_now;

  assign busy      = (state_ff == S_COMMIT) || (state_ff == S_WAIT);
  assign in_byte   = {sh_ff[BYTE_W-2:0], bit_ff};
  assign byte_done = rise_ev && (cnt_ff == BIT_LAST) && !busy;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_ff <= 4'h0;
      sh_ff  <= 8'h00;
    end else if (ce && !busy) begin
      if (start_ev) begin
        cnt_ff <= 4'h0;
      end else if (rise_ev) begin
        cnt_ff <= (cnt_ff == ACK_BIT) ? 4'h0 : cnt_ff + 4'h1;
        if (cnt_ff != ACK_BIT) begin
          sh_ff <= in_byte;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------------
  logic [TMR_W-1:0]  tmr_ff;
  logic [PAGE_W-1:0] idx_ff;
  logic              got_ff;

  always_comb begin
    nxt_state = state_ff;
    ack_now   = 1'b0;
    if (state_ff == S_COMMIT) begin
      if (idx_ff == PAGE_LAST) begin
        nxt_state = S_WAIT;
      end
    end else if (state_ff == S_WAIT) begin
      if (tmr_ff >= TMR_W'(WRITE_CYCLES - 1)) begin
        nxt_state = S_IDLE;
      end
    end else if (start_ev) begin
      nxt_state = S_CTRL;
    end else if (stop_ev) begin
      // The protect level is looked at here and nowhere else.
      nxt_state = (state_ff == S_DATA && got_ff && !wp_s) ? S_COMMIT : S_IDLE;
    end else if (byte_done) begin
      unique case (state_ff)
        S_CTRL: begin
          if (in_byte[7:4] == CTRL_CODE && in_byte[3:1] == sel_s) begin
            ack_now   = 1'b1;
            nxt_state = in_byte[0] ? S_READ : S_ADDR_HI;
          end else begin
            nxt_state = S_SKIP;
          end
        end
        S_ADDR_HI: begin
          ack_now   = 1'b1;
          nxt_state = S_ADDR_LO;
        end
        S_ADDR_LO: begin
          ack_now   = 1'b1;
          nxt_state = S_DATA;
        end
        S_DATA: begin
          ack_now = 1'b1;
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_ff <= S_IDLE;
      busy_ff  <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state == S_COMMIT) || (nxt_state == S_WAIT);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tmr_ff <= '0;
      idx_ff <= '0;
    end else if (ce) begin
      tmr_ff <= busy ? tmr_ff + TMR_W'(1) : '0;
      idx_ff <= (state_ff == S_COMMIT) ? idx_ff + 5'h01 : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Acknowledge drive
  // ----------------------------------------------------------------------
  // The line is pulled on the fall that ends the eighth bit and let go on the
  // fall that ends the acknowledge pulse, so it is steady while the clock is high.
  // A read is acknowledged but no data is shifted out; the line simply stays
  // released, which is what the master needs to see before its Stop.
  logic ack_pend_ff;
  logic sda_oe_n_ff;
  logic sda_o_ff;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_pend_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      sda_o_ff    <= 1'b0;
    end else if (ce) begin
      if (busy || start_ev || stop_ev) begin
        ack_pend_ff <= 1'b0;
        sda_oe_n_ff <= 1'b1;
      end else if (byte_done) begin
        ack_pend_ff <= ack_now;
      end else if (fall_ev) begin
        sda_oe_n_ff <= !ack_pend_ff;
        ack_pend_ff <= 1'b0;
      end
    end
  end

  assign link.dev_sda_oe_n = sda_oe_n_ff;
  assign link.dev_sda_o    = sda_o_ff;

  // ----------------------------------------------------------------------
  // Address pointer and page buffer
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0]     ptr_ff;
  logic [BYTE_W-1:0]     page_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid_ff;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ptr_ff   <= '0;
      valid_ff <= '0;
      got_ff   <= 1'b0;
    end else if (ce && byte_done) begin
      unique case (state_ff)
        S_CTRL: begin
          got_ff <= 1'b0;
        end
        S_ADDR_HI: begin
          ptr_ff[ADDR_W-1:BYTE_W] <= in_byte[3:0];
        end
        S_ADDR_LO: begin
          ptr_ff[BYTE_W-1:0] <= in_byte;
          valid_ff           <= '0;
        end
        S_DATA: begin
          // Only the low pointer bits move, so data wraps within the page.
          valid_ff[ptr_ff[PAGE_W-1:0]] <= 1'b1;
          ptr_ff[PAGE_W-1:0]           <= ptr_ff[PAGE_W-1:0] + 5'h01;
          got_ff                       <= 1'b1;
        end
        default: begin
          got_ff <= got_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ce && byte_done && state_ff == S_DATA) begin
      page_ff[ptr_ff[PAGE_W-1:0]] <= in_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------------
  // The commit walks the whole page one byte a cycle; unwritten bytes are
  // written back with their old contents, as the real cell array would.
  logic [BYTE_W-1:0] mem_ff [1 << ADDR_W];
  logic [ADDR_W-1:0] wr_addr;

  assign wr_addr = {ptr_ff[ADDR_W-1:PAGE_W], idx_ff};

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (state_ff == S_COMMIT) begin
        mem_ff[wr_addr] <= valid_ff[idx_ff] ? page_ff[idx_ff] : mem_ff[wr_addr];
      end
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule

// File: logic/ee_pkg.sv
// Shared constants for the two-wire serial EEPROM slave and its bus master.
// Assumes a 50 MHz system clock on both ends.
package ee_pkg;
  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int          BYTE_W     = 8;
  localparam int          ADDR_W     = 12;
  localparam int          PAGE_W     = 5;
  localparam int          PAGE_BYTES = 32;
  localparam logic [3:0]  CTRL_CODE  = 4'ha;
  localparam logic [3:0]  BIT_LAST   = 4'h7;
  localparam logic [3:0]  ACK_BIT    = 4'h8;
  localparam logic [PAGE_W-1:0] PAGE_LAST = 5'h1f;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int WRITE_TIME_MS = 5;
  // Longest time, so the cycle count rounds down.
  localparam int WRITE_CYCLES_DFLT = (WRITE_TIME_MS * (CLK_HZ / 1000));
  // Clock cycles per quarter of a bit on the serial clock made by the master.
  localparam int SCL_QUARTER_CYCLES = 4;
endpackage

// File: logic/ee_link_if.sv
// Two-wire link between the bus master end and the EEPROM slave end.
// The data line is open drain with a pull-up, resolved here from the enables.
`timescale 1ns/1ps
interface ee_link_if;
  logic scl;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic sda;

  assign sda = ((!dev_sda_oe_n && !dev_sda_o) || (!host_sda_oe_n && !host_sda_o)) ? 1'b0 : 1'b1;

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface

// File: logic/ee_sync.sv
// Two-flop synchroniser for a group of independent level signals.
// Each bit is a separate level; the group is not a coherent word.
`timescale 1ns/1ps
module ee_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule

// File: logic/ee_host_end.sv
// Bus master end: issues Start, byte, acknowledge and Stop on the two-wire link.
// The serial clock is made from clk_sys by a divider; no clock stretching.
`timescale 1ns/1ps
module ee_host_end
  import ee_pkg::*;
#(
  parameter int QUARTER = SCL_QUARTER_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              ce,
  ee_link_if.host                link,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_start,
  input  wire logic              cmd_stop,
  input  wire logic [BYTE_W-1:0] cmd_byte,
  output logic                   cmd_ready_ff,
  output logic                   ack_valid_ff,
  output logic                   ack_ok_ff
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_ACK, H_STOP} ee_host_state_e;

  localparam int QW = $clog2(QUARTER + 1);

  ee_host_state_e    state_ff;
  logic [QW-1:0]     q_ff;
  logic [1:0]        ph_ff;
  logic [2:0]        nbit_ff;
  logic [BYTE_W-1:0] byte_ff;
  logic              stop_ff;
  logic              scl_ff;
  logic              sda_oe_n_ff;
  logic              sda_o_ff;
  logic              sda_s;
  logic              tick;
  logic              hold;

  ee_sync #(.W(1)) u_sync (
    .clk    (clk_sys),
    .resetn (resetn),
    .ce     (ce),
    .d      (link.sda),
    .q      (sda_s)
  );

  // ----------------------------------------------------------------------
  // Quarter-bit timing
  // ----------------------------------------------------------------------
  assign tick = (q_ff == QW'(QUARTER - 1));
  // The Start waits with the clock high until the data line reads high.
  assign hold = (state_ff == H_START) && (ph_ff == 2'h2) && !sda_s;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      q_ff  <= '0;
      ph_ff <= 2'h0;
    end else if (ce) begin
      if (state_ff == H_IDLE || tick) begin
        q_ff <= '0;
      end else begin
        q_ff <= q_ff + QW'(1);
      end
      if (state_ff == H_IDLE) begin
        ph_ff <= 2'h0;
      end else if (tick && !hold) begin
        ph_ff <= ph_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Line sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_ff     <= H_IDLE;
      scl_ff       <= 1'b1;
      sda_oe_n_ff  <= 1'b1;
      sda_o_ff     <= 1'b0;
      cmd_ready_ff <= 1'b1;
      ack_valid_ff <= 1'b0;
      ack_ok_ff    <= 1'b0;
      nbit_ff      <= 3'h0;
      byte_ff      <= 8'h00;
      stop_ff      <= 1'b0;
    end else if (ce) begin
      ack_valid_ff <= 1'b0;
      unique case (state_ff)
        H_IDLE: begin
          if (cmd_valid && cmd_ready_ff) begin
            cmd_ready_ff <= 1'b0;
            byte_ff      <= cmd_byte;
            stop_ff      <= cmd_stop;
            nbit_ff      <= 3'h0;
            state_ff     <= cmd_start ? H_START : H_BIT;
          end
        end
        H_START: begin
          if (tick) begin
            unique case (ph_ff)
              2'h0: sda_oe_n_ff <= 1'b1;
              2'h1: scl_ff <= 1'b1;
              2'h2: sda_oe_n_ff <= !sda_s;
              2'h3: begin
                scl_ff   <= 1'b0;
                state_ff <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            unique case (ph_ff)
              2'h0: sda_oe_n_ff <= byte_ff[BYTE_W-1];
              2'h1: scl_ff <= 1'b1;
              2'h2: scl_ff <= 1'b1;
              2'h3: begin
                scl_ff  <= 1'b0;
                byte_ff <= {byte_ff[BYTE_W-2:0], 1'b0};
                nbit_ff <= nbit_ff + 3'h1;
                if (nbit_ff == 3'h7) begin
                  state_ff <= H_ACK;
                end
              end
            endcase
          end
        end
        H_ACK: begin
          if (tick) begin
            unique case (ph_ff)
              2'h0: sda_oe_n_ff <= 1'b1;
              2'h1: scl_ff <= 1'b1;
              2'h2: ack_ok_ff <= !sda_s;
              2'h3: begin
                scl_ff       <= 1'b0;
                ack_valid_ff <= 1'b1;
                state_ff     <= stop_ff ? H_STOP : H_IDLE;
                cmd_ready_ff <= !stop_ff;
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            unique case (ph_ff)
              2'h0: sda_oe_n_ff <= 1'b0;
              2'h1: scl_ff <= 1'b1;
              2'h2: sda_oe_n_ff <= 1'b1;
              2'h3: begin
                state_ff     <= H_IDLE;
                cmd_ready_ff <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  assign link.scl           = scl_ff;
  assign link.host_sda_oe_n = sda_oe_n_ff;
  assign link.host_sda_o    = sda_o_ff;
endmodule

// File: verif/ee_link_assertions.sv
// Concurrent checks on the two-wire link between the host end and the device end.
// Assumes the host runs with QUARTER = 4, so each serial clock high phase spans at least 8 cycles.
`timescale 1ns/1ps
module ee_link_assertions (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n
);
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  logic       scl_q_ff;
  logic       sda_q_ff;
  logic [3:0] rise_cnt_ff;

  always_ff @(posedge clk_sys) begin
    scl_q_ff <= scl;
    sda_q_ff <= sda;
  end

  // Rises since the last Start; the ninth rise of every byte is its acknowledge.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rise_cnt_ff <= 4'h0;
    end else if (scl && scl_q_ff && sda_q_ff && !sda) begin
      rise_cnt_ff <= 4'h0;
    end else if (scl && !scl_q_ff) begin
      rise_cnt_ff <= (rise_cnt_ff == 4'h9) ? 4'h1 : rise_cnt_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  AST_OPEN_DRAIN: assert property (!dev_sda_o && !host_sda_o)
    else $error("data line driven high by an end");
  AST_DEV_STABLE_SCL_HIGH: assert property ($rose(scl) |-> $stable(dev_sda_oe_n)[*7])
    else $error("device changed data while clock high");
  AST_HOST_STABLE_SCL_HIGH: assert property ($rose(scl) |-> $stable(host_sda_oe_n)[*4])
    else $error("host changed data early in clock high");
  AST_SCL_PULSE: assert property ($rose(scl) |-> scl[*7])
    else $error("clock high phase too short");
  AST_ACK_HELD_LOW: assert property (!dev_sda_oe_n && $rose(scl) |-> (!sda)[*7])
    else $error("acknowledge not held low through clock high");
  AST_ACK_NINTH: assert property ($fell(dev_sda_oe_n) |-> rise_cnt_ff == 4'h8 && !scl)
    else $error("device pulled data outside the acknowledge slot");
  AST_ACK_RELEASE: assert property ($fell(scl) && !dev_sda_oe_n |-> ##[1:8] dev_sda_oe_n)
    else $error("device did not release data after acknowledge");
  AST_ACK_OWNER: assert property ($rose(scl) && rise_cnt_ff == 4'h8 && !sda |-> !dev_sda_oe_n)
    else $error("acknowledge slot low without the device");
  AST_START_IDLE: assert property (scl && $fell(sda) |-> $past(sda, 4) && $past(scl, 4))
    else $error("start issued on a busy bus");

  COV_START: cover property (scl && $fell(sda));
  COV_ACK: cover property ($rose(scl) && rise_cnt_ff == 4'h8 && !sda);
  COV_STOP: cover property (scl && $rose(sda));
endmodule

// File: verif/i2c_eeprom_slave_write_tb.sv
// Self-checking bench: host end and device end joined by one link interface.
// Assumes the design files under logic/ are compiled first.
`timescale 1ns/1ps
module i2c_eeprom_slave_write_tb;
  import ee_pkg::*;
  // Short write cycle keeps the run small; it must outlast one control byte.
  localparam int WC = 400;
  logic        clk_sys;
  logic        resetn;
  logic        wp;
  logic [2:0]  pins;
  logic        cmd_valid;
  logic        cmd_start;
  logic        cmd_stop;
  logic [7:0]  cmd_byte;
  logic        cmd_ready_ff;
  logic        ack_valid_ff;
  logic        ack_ok_ff;
  logic [11:0] rd_addr;
  logic [7:0]  rd_data_ff;
  logic        busy_ff;
  int          err_total;
  int          checks_done;

  ee_link_if link ();
  ee_host_end ee_host_end_i (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_byte(cmd_byte),
    .cmd_ready_ff(cmd_ready_ff), .ack_valid_ff(ack_valid_ff), .ack_ok_ff(ack_ok_ff));
  ee_dev_end #(.WRITE_CYCLES(WC)) ee_dev_end_i (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
    .link(link.dev), .wp(wp), .chip_addr_pin_0(pins[0]), .chip_addr_pin_1(pins[1]),
    .chip_addr_pin_2(pins[2]), .rd_addr(rd_addr), .rd_data_ff(rd_data_ff), .busy_ff(busy_ff));
  ee_link_assertions ee_link_assertions_i (.clk_sys(clk_sys), .resetn(resetn), .scl(link.scl),
    .sda(link.sda), .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n),
    .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout();
    err_total++;
    conclude();
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int n = 0; busy_ff !== lvl; n++) begin
      tick();
      if (n > 1000) timeout();
    end
  endtask
  // One byte on the host port; the request holds until the edge that takes it.
  task automatic xfer(input logic st, input logic sp, input logic [7:0] b, input logic exp);
    for (int n = 0; cmd_ready_ff !== 1'b1; n++) begin
      tick();
      if (n > 1000) timeout();
    end
    cmd_valid = 1'b1;
    cmd_start = st;
    cmd_stop = sp;
    cmd_byte = b;
    tick();
    cmd_valid = 1'b0;
    for (int n = 0; ack_valid_ff !== 1'b1; n++) begin
      tick();
      if (n > 1000) timeout();
    end
    chk(32'(ack_ok_ff), 32'(exp));
  endtask
  task automatic write_bytes(input logic [15:0] a, input int n, input logic [7:0] d0);
    xfer(1'b1, 1'b0, {CTRL_CODE, pins, 1'b0}, 1'b1);
    xfer(1'b0, 1'b0, a[15:8], 1'b1);
    xfer(1'b0, n == 0, a[7:0], 1'b1);
    for (int k = 0; k < n; k++) begin
      xfer(1'b0, k == n - 1, d0 + 8'(k), 1'b1);
    end
  endtask
  // Watches the write cycle that a Stop should or should not start.
  task automatic commit(input logic exp_busy);
    int n;
    int hi;
    n = 0;
    hi = 0;
    while (busy_ff !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    while (busy_ff === 1'b1 && hi < WC + 8) begin
      tick();
      hi++;
    end
    chk(32'(hi != 0), 32'(exp_busy));
    chk(32'(hi <= WC), 32'h1);
  endtask
  task automatic peek(input logic [11:0] a, input logic [7:0] exp);
    rd_addr = a;
    tick();
    tick();
    chk(32'(rd_data_ff), 32'(exp));
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic s_byte_write();
    write_bytes(16'hf123, 1, 8'h5a);
    wait_busy(1'b1);
    xfer(1'b1, 1'b1, {CTRL_CODE, pins, 1'b0}, 1'b0);
    wait_busy(1'b0);
    xfer(1'b1, 1'b1, {CTRL_CODE, pins, 1'b0}, 1'b1);
    peek(12'h123, 8'h5a);
  endtask
  task automatic s_select();
    xfer(1'b1, 1'b1, {4'hb, pins, 1'b0}, 1'b0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 1'b1, {CTRL_CODE, pins ^ (3'h1 << i), 1'b0}, 1'b0);
    end
    pins = 3'h2;
    repeat (8) tick();
    xfer(1'b1, 1'b1, {CTRL_CODE, pins, 1'b0}, 1'b1);
  endtask
  // Thirty-four bytes from page offset 28: the pointer wraps in the page.
  task automatic s_page();
    int k;
    write_bytes(16'h003c, 34, 8'h40);
    commit(1'b1);
    for (int o = 0; o < 32; o++) begin
      k = (o + 4) % 32;
      if (k < 2) k += 32;
      peek(12'h020 + 12'(o), 8'h40 + 8'(k));
    end
    write_bytes(16'h003d, 1, 8'hee);
    commit(1'b1);
    peek(12'h03d, 8'hee);
    peek(12'h03c, 8'h60);
    peek(12'h03e, 8'h42);
  endtask
  task automatic s_protect();
    wp = 1'b1;
    write_bytes(16'h0020, 1, 8'h99);
    commit(1'b0);
    xfer(1'b1, 1'b1, {CTRL_CODE, pins, 1'b0}, 1'b1);
    peek(12'h020, 8'h44);
    wp = 1'b0;
    write_bytes(16'h0021, 1, 8'h77);
    wait_busy(1'b1);
    wp = 1'b1;
    wait_busy(1'b0);
    peek(12'h021, 8'h77);
    wp = 1'b0;
  endtask
  task automatic s_read();
    xfer(1'b1, 1'b0, {CTRL_CODE, pins, 1'b1}, 1'b1);
    xfer(1'b0, 1'b1, 8'hff, 1'b0);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    resetn = 1'b0;
    wp = 1'b0;
    pins = 3'h5;
    cmd_valid = 1'b0;
    cmd_start = 1'b0;
    cmd_stop = 1'b0;
    cmd_byte = 8'h00;
    rd_addr = 12'h000;
    repeat (8) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    tick();
    s_byte_write();
    s_select();
    s_page();
    s_protect();
    s_read();
    conclude();
  end
endmodule
